// >>> core/pti_reader.sv
// Paper-tape input channel: busbar selection, character gate-out with optional
// odd-parity check, tape advance sequencer and an AXI4-Lite register slave.
// Assumes select, deselect and gate-out strobes come from logic on clk_i, and
// hole and sprocket sense come from the mechanism as asynchronous pins.
`timescale 1ns/1ps

module pti_reader
   import pti_pkg::*;
#(
   parameter int IN_W        = 18,
   parameter int OUT_W       = 18,
   parameter bit HAS_PARITY  = 1'b1,
   parameter int TIMEOUT_CYC = pti_pkg::TIMEOUT_DFLT
) (
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      reset_n_i,
   // Controller busbars and strobes
   input  wire logic [IN_W-1:0]           in_bus_i,
   input  wire logic                      input_device_select_i,
   input  wire logic                      input_device_deselect_i,
   input  wire logic                      gate_out_input_register_i,
   output logic      [OUT_W-1:0]          out_bus_o,
   output logic                           out_strobe_o,
   output logic                           busy_o,
   // Reading mechanism
   input  wire logic [pti_pkg::CHAR_W-1:0] hole_sense_i,
   input  wire logic                      sprocket_i,
   output logic                           clutch_o,
   output logic                           brake_o,
   // AXI4-Lite slave
   input  wire logic [pti_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [pti_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // Interrupt
   output logic                           irq_o
);

   import pti_pkg::*;

   localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);

   typedef enum logic [1:0] {M_IDLE, M_LEAVE, M_ARRIVE, M_SETTLE} pti_motion_e;

   logic [CHAR_W-1:0] holes_s;
   logic              sprocket_s;

   pti_sync #(.W(CHAR_W + 1)) u_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({sprocket_i, hole_sense_i}),
      .sync_o    ({sprocket_s, holes_s})
   );

   // Busbar side state.
   pti_sel_e          sel_q, sel_d;
   logic              perr_q, perr_d;
   logic [OUT_W-1:0]  out_d;
   logic              strobe_d;
   logic [CHAR_W-1:0] last_q, last_d;
   // Motion state.
   pti_motion_e       mst_q, mst_d;
   logic [CNT_W-1:0]  cnt_q, cnt_d;
   // Separate count of settle cycles, so the settle check does not lean on cnt_q.
   logic [7:0]        settle_run_q, settle_run_d;
   // Register state.
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [EV_W-1:0]   ist_q, ist_d;
   logic [EV_W-1:0]   msk_q, msk_d;
   logic              awv_q, awv_d, wv_q, wv_d;
   logic [AXI_AW-1:0] awa_q, awa_d;
   logic [31:0]       wd_q, wd_d;
   logic              wb0_q, wb0_d;
   logic              bv_d, rv_d;
   logic [1:0]        br_d, rr_d;
   logic [31:0]       rd_d;

   logic [CLASS_W-1:0] cls;
   logic               par_on;
   logic               gate_ok;
   logic               gate_refused;
   logic               char_even;
   logic               timeout_hit;
   logic [EV_W-1:0]    events;

   assign cls          = in_bus_i[CLASS_W-1:0];
   assign par_on       = HAS_PARITY && ctrl_q[CTRL_PAR_BIT];
   assign char_even    = ~^holes_s;
   // A gate-out while the tape moves would catch a half-punched row, so it is refused.
   assign gate_ok      = gate_out_input_register_i && (sel_q == SEL_TAPE)
                         && (mst_q == M_IDLE) && ctrl_q[CTRL_RUN_BIT];
   assign gate_refused = gate_out_input_register_i && (sel_q == SEL_TAPE) && !gate_ok;
   assign timeout_hit  = ((mst_q == M_LEAVE) || (mst_q == M_ARRIVE))
                         && (cnt_q == CNT_W'(TIMEOUT_CYC - 1));

   always_comb begin
      sel_d    = sel_q;
      perr_d   = perr_q;
      out_d    = out_bus_o;
      strobe_d = 1'b0;
      last_d   = last_q;
      if (input_device_deselect_i) begin
         sel_d = SEL_NONE;
      end else if (input_device_select_i) begin
         if (cls == CLASS_TAPE) begin
            sel_d = SEL_TAPE;
         end else if (HAS_PARITY && cls == CLASS_PARITY) begin
            sel_d = SEL_PARITY;
         end else begin
            sel_d = SEL_NONE;
         end
      end
      if (gate_ok) begin
         strobe_d = 1'b1;
         last_d   = holes_s;
         out_d    = '0;
         if (par_on) begin
            out_d[DATA_BITS-1:0] = holes_s[DATA_BITS-1:0];
            if (char_even) begin
               perr_d = 1'b1;
            end
         end else begin
            out_d[CHAR_W-1:0] = holes_s;
         end
      end else if (gate_out_input_register_i && sel_q == SEL_PARITY) begin
         strobe_d         = 1'b1;
         out_d            = '0;
         out_d[OUT_W-1]   = perr_q;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sel_q        <= SEL_NONE;
         perr_q       <= 1'b0;
         out_bus_o    <= '0;
         out_strobe_o <= 1'b0;
         last_q       <= '0;
      end else begin
         sel_q        <= sel_d;
         perr_q       <= perr_d;
         out_bus_o    <= out_d;
         out_strobe_o <= strobe_d;
         last_q       <= last_d;
      end
   end

   // Advance: clutch until the sprocket hole leaves and the next one arrives,
   // then brake and let the row settle under the read head.
   always_comb begin
      mst_d = mst_q;
      cnt_d = cnt_q + CNT_W'(1);
      settle_run_d = (mst_q == M_SETTLE) ? settle_run_q + 8'h01 : 8'h00;
      case (mst_q)
         M_IDLE: begin
            cnt_d = '0;
            if (gate_ok) begin
               mst_d = M_LEAVE;
            end
         end
         M_LEAVE: begin
            if (timeout_hit) begin
               mst_d = M_IDLE;
            end else if (!sprocket_s) begin
               mst_d = M_ARRIVE;
               cnt_d = '0;
            end
         end
         M_ARRIVE: begin
            if (timeout_hit) begin
               mst_d = M_IDLE;
            end else if (sprocket_s) begin
               mst_d = M_SETTLE;
               cnt_d = '0;
            end
         end
         M_SETTLE: begin
            if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
               mst_d = M_IDLE;
            end
         end
         default: begin
            mst_d = M_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mst_q        <= M_IDLE;
         cnt_q        <= '0;
         settle_run_q <= '0;
      end else begin
         mst_q        <= mst_d;
         cnt_q        <= cnt_d;
         settle_run_q <= settle_run_d;
      end
   end

   assign busy_o   = (mst_q != M_IDLE);
   assign clutch_o = (mst_q == M_LEAVE) || (mst_q == M_ARRIVE);
   assign brake_o  = !clutch_o;

   assign events = {timeout_hit, gate_refused, gate_ok && par_on && char_even, gate_ok};
   assign irq_o  = |(ist_q & msk_q);

   // Register slave: address and data are held separately and the write is
   // done once both are in, which costs a cycle but keeps the decode simple.
   assign s_axi_awready = !awv_q && !s_axi_bvalid;
   assign s_axi_wready  = !wv_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      awv_d  = awv_q;
      awa_d  = awa_q;
      wv_d   = wv_q;
      wd_d   = wd_q;
      wb0_d  = wb0_q;
      bv_d   = s_axi_bvalid && !s_axi_bready;
      br_d   = s_axi_bresp;
      rv_d   = s_axi_rvalid && !s_axi_rready;
      rr_d   = s_axi_rresp;
      rd_d   = s_axi_rdata;
      ctrl_d = ctrl_q;
      msk_d  = msk_q;
      ist_d  = ist_q;
      if (s_axi_awvalid && s_axi_awready) begin
         awv_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wv_d  = 1'b1;
         wd_d  = s_axi_wdata;
         wb0_d = s_axi_wstrb[0];
      end
      if (awv_q && wv_q) begin
         awv_d = 1'b0;
         wv_d  = 1'b0;
         bv_d  = 1'b1;
         br_d  = RESP_OKAY;
         case (awa_q)
            ADDR_CTRL: begin
               if (wb0_q) begin
                  ctrl_d = wd_q[CTRL_W-1:0];
               end
            end
            ADDR_STATUS: begin
            end
            ADDR_IRQ_ST: begin
               if (wb0_q) begin
                  ist_d = ist_q & ~wd_q[EV_W-1:0];
               end
            end
            ADDR_IRQ_MSK: begin
               if (wb0_q) begin
                  msk_d = wd_q[EV_W-1:0];
               end
            end
            default: begin
               br_d = RESP_SLVERR;
            end
         endcase
      end
      // Events are merged last so a set in the clearing cycle is kept.
      ist_d = ist_d | events;
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rr_d = RESP_OKAY;
         rd_d = '0;
         case (s_axi_araddr)
            ADDR_CTRL:    rd_d[CTRL_W-1:0] = ctrl_q;
            ADDR_STATUS: begin
               rd_d[ST_BUSY_BIT]                  = busy_o;
               rd_d[ST_PERR_BIT]                  = perr_q;
               rd_d[ST_SEL_LSB +: 2]              = sel_q;
               rd_d[ST_CHAR_LSB +: CHAR_W]        = last_q;
            end
            ADDR_IRQ_ST:  rd_d[EV_W-1:0] = ist_q;
            ADDR_IRQ_MSK: rd_d[EV_W-1:0] = msk_q;
            default:      rr_d = RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         awv_q        <= 1'b0;
         awa_q        <= '0;
         wv_q         <= 1'b0;
         wd_q         <= '0;
         wb0_q        <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= '0;
         ctrl_q       <= CTRL_RST;
         msk_q        <= MASK_RST;
         ist_q        <= '0;
      end else begin
         awv_q        <= awv_d;
         awa_q        <= awa_d;
         wv_q         <= wv_d;
         wd_q         <= wd_d;
         wb0_q        <= wb0_d;
         s_axi_bvalid <= bv_d;
         s_axi_bresp  <= br_d;
         s_axi_rvalid <= rv_d;
         s_axi_rresp  <= rr_d;
         s_axi_rdata  <= rd_d;
         ctrl_q       <= ctrl_d;
         msk_q        <= msk_d;
         ist_q        <= ist_d;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_char_gated: assert property (gate_ok && !par_on |=>
      out_strobe_o && out_bus_o == OUT_W'($past(holes_s)))
      else $error("tape character not gated onto low busbars");
   a_advance_start: assert property (gate_ok |=> clutch_o && busy_o ##1 busy_o)
      else $error("gate-out did not start a tape advance");
   a_parity_latch: assert property (gate_ok && par_on && char_even |=> perr_q)
      else $error("even-parity character did not latch the error");
   a_class_tape: assert property (input_device_select_i && !input_device_deselect_i
      && cls == CLASS_TAPE |=> sel_q == SEL_TAPE)
      else $error("class 3 select did not pick the tape channel");
   a_class_parity: assert property (HAS_PARITY && input_device_select_i
      && !input_device_deselect_i && cls == CLASS_PARITY |=> sel_q == SEL_PARITY)
      else $error("class 6 select did not pick the parity channel");
   a_parity_out: assert property (gate_out_input_register_i && sel_q == SEL_PARITY
      |=> out_strobe_o && out_bus_o == {$past(perr_q), (OUT_W-1)'(0)})
      else $error("parity channel gate-out gave a wrong word");
   a_four_bits: assert property (gate_ok && par_on |=>
      out_bus_o == OUT_W'($past(holes_s[DATA_BITS-1:0])))
      else $error("parity hole leaked onto the busbars");
   a_perr_sticky: assert property (perr_q |=> perr_q)
      else $error("parity error dropped without reset");
   a_deselect: assert property (input_device_deselect_i |=> sel_q == SEL_NONE)
      else $error("deselect left a channel selected");
   a_busy_motion: assert property (clutch_o |-> busy_o && !brake_o)
      else $error("tape moving without busy");
   a_settle_len: assert property ($fell(mst_q == M_SETTLE) |->
      !busy_o && brake_o && settle_run_q == 8'(SETTLE_CYC))
      else $error("settle period has the wrong length");
   a_no_gate_busy: assert property (busy_o && gate_out_input_register_i
      && sel_q == SEL_TAPE |=> !out_strobe_o && (mst_q != M_LEAVE || $past(mst_q) == M_LEAVE))
      else $error("gate-out during motion restarted the advance");

   c_char_read: cover property (gate_ok ##[1:200] !busy_o);
   c_parity_err: cover property (gate_ok && par_on && char_even);
   c_parity_read: cover property (perr_q && gate_out_input_register_i && sel_q == SEL_PARITY);
   c_refused: cover property (gate_refused);

endmodule

// >>> core/pti_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the inputs are asynchronous pins; the output follows a change only
// once the second and third stages agree.
`timescale 1ns/1ps
module pti_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         reset_n_i,
   // Pins and clean result
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] f1_q;
   logic [W-1:0] f2_q;
   logic [W-1:0] f3_q;
   logic [W-1:0] out_d;

   always_comb begin
      out_d = sync_o;
      for (int i = 0; i < W; i++) begin
         if (f2_q[i] == f3_q[i]) begin
            out_d[i] = f3_q[i];
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         f1_q   <= '0;
         f2_q   <= '0;
         f3_q   <= '0;
         sync_o <= '0;
      end else begin
         f1_q   <= async_i;
         f2_q   <= f1_q;
         f3_q   <= f2_q;
         sync_o <= out_d;
      end
   end

endmodule

// >>> shared/pti_pkg.sv
// Constants shared by the paper-tape input channel: register map, field layout,
// reset values, busbar address classes and motion timing.
// Assumes a single 20 MHz system clock.
package pti_pkg;

   // Clock.
   localparam int CLK_PERIOD_NS = 50;

   // Busbar address classes and field widths.
   localparam int         CLASS_W      = 4;
   localparam logic [3:0] CLASS_TAPE   = 4'h3;
   localparam logic [3:0] CLASS_PARITY = 4'h6;
   localparam int         CHAR_W       = 5;
   localparam int         DATA_BITS    = 4;

   // Motion timing.
   localparam int SETTLE_NS    = 2000;
   localparam int SETTLE_CYC   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMEOUT_MS   = 50;
   localparam int TIMEOUT_DFLT = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

   // Register map (byte addresses).
   localparam int          AXI_AW       = 4;
   localparam logic [3:0]  ADDR_CTRL    = 4'h0;
   localparam logic [3:0]  ADDR_STATUS  = 4'h4;
   localparam logic [3:0]  ADDR_IRQ_ST  = 4'h8;
   localparam logic [3:0]  ADDR_IRQ_MSK = 4'hC;

   // Control fields.
   localparam int         CTRL_RUN_BIT = 0;
   localparam int         CTRL_PAR_BIT = 1;
   localparam int         CTRL_W       = 2;
   localparam logic [1:0] CTRL_RST     = 2'h3;

   // Status fields.
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_PERR_BIT = 1;
   localparam int ST_SEL_LSB  = 2;
   localparam int ST_CHAR_LSB = 8;

   // Interrupt events.
   localparam int         EV_CHAR    = 0;
   localparam int         EV_PERR    = 1;
   localparam int         EV_REFUSE  = 2;
   localparam int         EV_TIMEOUT = 3;
   localparam int         EV_W       = 4;
   localparam logic [3:0] MASK_RST   = 4'h0;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {SEL_NONE, SEL_TAPE, SEL_PARITY} pti_sel_e;

endpackage

// >>> tb/pti_tape_model.sv
// Behavioural tape-reading mechanism: moves one row per clutch engagement.
// Assumes the reader drives clutch on clk_i; stall_i freezes the tape for fault runs.
`timescale 1ns/1ps
module pti_tape_model #(
   parameter int D = 10
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   // Drive from the reader and from the bench
   input  wire logic       clutch_i,
   input  wire logic       stall_i,
   input  wire logic [4:0] next_char_i,
   // Sense lines back to the reader
   output logic      [4:0] hole_sense_o,
   output logic            sprocket_o
);
   logic [7:0] cnt_q;
   logic [4:0] cur_q;
   // In transit the holes show a garbled row, so an early sample reads junk, not the old row.
   assign hole_sense_o = (cnt_q > D && cnt_q <= 2 * D) ? ~cur_q : cur_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q      <= 8'h00;
         cur_q      <= next_char_i;
         sprocket_o <= 1'b1;
      end else if (!clutch_i) begin
         cnt_q <= 8'h00;
      end else if (!stall_i) begin
         cnt_q <= cnt_q + 8'h01;
         if (cnt_q == 8'(D)) sprocket_o <= 1'b0;
         if (cnt_q == 8'(2 * D)) cur_q <= next_char_i;
         if (cnt_q == 8'(2 * D + 4)) sprocket_o <= 1'b1;
      end
   end
endmodule

// >>> tb/tb_pti_reader.sv
// Self-checking bench for the paper-tape input channel with a tape mechanism model.
// Assumes the controller strobes and the AXI4-Lite master are driven from clk_i here.
`timescale 1ns/1ps
module tb_pti_reader;
   import pti_pkg::*;
   logic clk_i = 1'b0, reset_n_i = 1'b0, stall = 1'b0;
   logic sel = 1'b0, desel = 1'b0, gate = 1'b0, out_strobe_o, busy_o, clutch_o, brake_o;
   logic sprocket_i, irq_o;
   logic [17:0] in_bus_i = 18'h00000, out_bus_o;
   logic [4:0] hole_sense_i, nc = 5'h15;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   int error_cnt = 0, checked = 0;

   always #25 clk_i = ~clk_i;

   pti_reader #(.TIMEOUT_CYC(200)) i_dut (.clk_i, .reset_n_i, .in_bus_i,
      .input_device_select_i(sel), .input_device_deselect_i(desel),
      .gate_out_input_register_i(gate), .out_bus_o, .out_strobe_o, .busy_o, .hole_sense_i,
      .sprocket_i, .clutch_o, .brake_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o);
   pti_tape_model #(.D(10)) i_tape (.clk_i, .reset_n_i, .clutch_i(clutch_o), .stall_i(stall),
      .next_char_i(nc), .hole_sense_o(hole_sense_i), .sprocket_o(sprocket_i));

   task automatic results();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Ready is sampled at the falling edge, where it already holds its value for the next rise.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic aw_d, w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge clk_i);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!(aw_d && w_d)) begin
         @(negedge clk_i);
         aw_d = aw_d | s_axi_awready;
         w_d = w_d | s_axi_wready;
         @(posedge clk_i);
         if (aw_d) s_axi_awvalid <= 1'b0;
         if (w_d) s_axi_wvalid <= 1'b0;
      end
      do @(negedge clk_i); while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      @(posedge clk_i);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rdr(input logic [3:0] a);
      @(posedge clk_i);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do @(negedge clk_i); while (s_axi_arready !== 1'b1);
      @(posedge clk_i);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk_i); while (s_axi_rvalid !== 1'b1);
      {rd, rs} = {s_axi_rdata, s_axi_rresp};
      @(posedge clk_i);
      s_axi_rready <= 1'b0;
   endtask

   task automatic pick(input logic [3:0] cls);
      @(posedge clk_i);
      desel <= 1'b1;
      @(posedge clk_i);
      desel <= 1'b0;
      sel <= 1'b1;
      in_bus_i <= {14'h0, cls};
      @(posedge clk_i);
      sel <= 1'b0;
   endtask

   task automatic gate_chk(input logic stb, input logic [17:0] bus, input logic bsy);
      @(posedge clk_i);
      gate <= 1'b1;
      @(posedge clk_i);
      gate <= 1'b0;
      @(negedge clk_i);
      chk("strobe", 32'(stb), 32'(out_strobe_o));
      chk("out_bus", 32'(bus), 32'(out_bus_o));
      chk("busy", 32'(bsy), 32'(busy_o));
      chk("clutch", 32'(bsy), 32'(clutch_o));
      chk("brake", 32'(!bsy), 32'(brake_o));
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy_o !== 1'b0 && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      chk("idle", 32'h1, 32'(n < 2000));
   endtask

   task automatic t_reset();
      rdr(ADDR_CTRL);
      chk("ctrl", 32'(CTRL_RST), rd);
      rdr(ADDR_IRQ_MSK);
      chk("mask", 32'(MASK_RST), rd);
      rdr(ADDR_STATUS);
      chk("perr", 32'h0, 32'(rd[1:0]));
      chk("irq", 32'h0, 32'(irq_o));
      $display("test reset done");
   endtask

   task automatic t_select();
      pick(CLASS_TAPE);
      rdr(ADDR_STATUS);
      chk("sel", 32'h1, 32'(rd[3:2]));
      pick(4'h5);
      rdr(ADDR_STATUS);
      chk("sel", 32'h0, 32'(rd[3:2]));
      pick(CLASS_PARITY);
      rdr(ADDR_STATUS);
      chk("sel", 32'h2, 32'(rd[3:2]));
      $display("test select done");
   endtask

   task automatic t_plain();
      wr(ADDR_CTRL, 32'h1);
      pick(CLASS_TAPE);
      gate_chk(1'b1, 18'h00015, 1'b1);
      nc = 5'h0C;
      wait_idle();
      gate_chk(1'b1, 18'h0000C, 1'b1);
      nc = 5'h0A;
      rdr(ADDR_STATUS);
      chk("char", 32'h0C, 32'(rd[12:8]));
      wait_idle();
      $display("test plain done");
   endtask

   task automatic t_parity();
      wr(ADDR_CTRL, 32'h3);
      gate_chk(1'b1, 18'h0000A, 1'b1);
      nc = 5'h07;
      wait_idle();
      rdr(ADDR_STATUS);
      chk("perr", 32'h1, 32'(rd[1]));
      gate_chk(1'b1, 18'h00007, 1'b1);
      nc = 5'h1F;
      wait_idle();
      rdr(ADDR_STATUS);
      chk("perr", 32'h1, 32'(rd[1]));
      pick(CLASS_PARITY);
      gate_chk(1'b1, 18'h20000, 1'b0);
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      pick(CLASS_PARITY);
      gate_chk(1'b1, 18'h00000, 1'b0);
      $display("test parity done");
   endtask

   task automatic t_irq();
      wr(ADDR_IRQ_MSK, 32'h4);
      pick(CLASS_TAPE);
      gate_chk(1'b1, 18'h0000F, 1'b1);
      gate_chk(1'b0, 18'h0000F, 1'b1);
      repeat (3) @(negedge clk_i);
      chk("irq", 32'h1, 32'(irq_o));
      wr(ADDR_IRQ_MSK, 32'h0);
      repeat (3) @(negedge clk_i);
      chk("irq", 32'h0, 32'(irq_o));
      wait_idle();
      wr(ADDR_IRQ_ST, 32'hF);
      rdr(ADDR_IRQ_ST);
      chk("irq_st", 32'h0, rd);
      wr(ADDR_CTRL, 32'h2);
      gate_chk(1'b0, 18'h0000F, 1'b0);
      rdr(4'h2);
      chk("rresp", 32'(RESP_SLVERR), 32'(rs));
      wr(4'h2, 32'h1);
      chk("bresp", 32'(RESP_SLVERR), 32'(rs));
      $display("test irq done");
   endtask

   task automatic t_timeout();
      wr(ADDR_CTRL, 32'h3);
      stall <= 1'b1;
      gate_chk(1'b1, 18'h0000F, 1'b1);
      wait_idle();
      stall = 1'b0;
      rdr(ADDR_IRQ_ST);
      chk("timeout", 32'h1, 32'(rd[EV_TIMEOUT]));
      // Byte lane 0 off must leave the mask untouched.
      s_axi_wstrb <= 4'hE;
      wr(ADDR_IRQ_MSK, 32'hF);
      s_axi_wstrb <= 4'hF;
      rdr(ADDR_IRQ_MSK);
      chk("wstrb", 32'h0, rd);
      $display("test timeout done");
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      t_reset();
      t_select();
      t_plain();
      t_parity();
      t_irq();
      t_timeout();
      results();
   end

   // The whole sequence needs under a thousand cycles; this leaves ample room.
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      results();
   end
endmodule
